//--- include/csir_regs.svh
// register offsets, field positions and reset values for the core status block
// assumes byte addressing on a 32-bit apb bus, one register per word
`ifndef CSIR_REGS_SVH
`define CSIR_REGS_SVH
`define CSIR_IDX_STATUS 9'h003
`define CSIR_IDX_INTCTL 9'h00b
`define CSIR_IDX_PFLAGS 9'h00c
`define CSIR_IDX_OPTION 9'h081
`define CSIR_IDX_PENABLE 9'h08c
`define CSIR_IDX_EVENTS 9'h0f0
`define CSIR_RST_STATUS 8'h18
`define CSIR_RST_OPTION 8'hff
`define CSIR_RST_INTCTL 8'h00
`define CSIR_RST_PFLAGS 8'h00
`define CSIR_RST_PENABLE 8'h00
`define CSIR_B_IRP 7
`define CSIR_B_TO 4
`define CSIR_B_PD 3
`define CSIR_B_Z 2
`define CSIR_B_DC 1
`define CSIR_B_C 0
`define CSIR_B_GIE 7
`define CSIR_B_PERIPHERAL_IRQ_GATE 6
`define CSIR_B_T0IF 2
`define CSIR_B_EXT_PIN_IRQ_FLAG 1
`define CSIR_B_PORT_CHANGE_FLAG 0
`define CSIR_B_ADC 6
`define CSIR_B_RX 5
`define CSIR_B_TX 4
`define CSIR_B_SSP 3
`endif

//--- include/csir_pkg.sv
// types shared by the core status block
// assumes the alu drives an op kind each instruction cycle
package csir_pkg;
  typedef enum logic [2:0] {
    csir_op_none,
    csir_op_logic,
    csir_op_add,
    csir_op_sub,
    csir_op_rrf,
    csir_op_rlf
  } csir_op_t;
endpackage

//--- verilog/csir_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes ref_clk domain and a synchronous reset
`timescale 1ns/1ps
module csir_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- verilog/csir_core.sv
// core status, option and interrupt registers behind an apb slave
// assumes the alu, watchdog and peripherals live outside on ref_clk
// Behaviour
// - alu flag writes lose, timeout/powerdown read-only
// - bit 7 picks indirect bank pair
// - bits 6-5 pick direct 128-byte bank
// - timeout bit set by clear/sleep, cleared expiry
// - powerdown bit set by clear, cleared sleep
// - zero flag follows result zero
// - digit carry from low nibble, borrow inverted
// - carry out of msb, one means no borrow
// - rotates load carry with shifted-out bit
// - option bit 7 disables port pull-ups
// - option bit 6 picks external edge
// - option bit 5 picks timer0 source
// - option bit 4 picks timer pin edge
// - option bit 3 assigns prescaler, else 1:1
// - rate field sets prescale ratio
// - flags set regardless of enables
// - global and peripheral gates qualify interrupts
// - three enable/flag pairs in interrupt control
// - port change flag re-sets while mismatch
// - peripheral enables, bit 7 reads zero
// - rx/tx flags read-only, follow buffers
// - sync serial and converter flags on done
// - capture/compare flag on capture or match
// - timer2 match and timer1 overflow flags
`timescale 1ns/1ps
`include "csir_regs.svh"
module csir_core #(
  parameter bit HAS_ADC = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csir_pkg::csir_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_dest_status,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic timer0_overflow,
  input wire logic external_irq_pin,
  input wire logic [3:0] second_port_hi,
  input wire logic second_port_read,
  input wire logic serial_rx_full,
  input wire logic serial_tx_empty,
  input wire logic sync_serial_done,
  input wire logic converter_done,
  input wire logic capcomp_event,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  output logic [7:0] alu_result,
  output logic indirect_bank_bit,
  output logic [1:0] direct_bank_field,
  output logic [8:0] direct_bank_base,
  output logic pullup_disable_n,
  output logic ext_irq_edge_sel,
  output logic timer0_source_sel,
  output logic timer0_edge_sel,
  output logic prescaler_owner_sel,
  output logic [8:0] timer0_prescale_div,
  output logic [7:0] watchdog_prescale_div,
  output logic irq_req
);
  logic [7:0] status_q, status_d, option_q, intctl_q, intctl_d;
  logic [7:0] pflags_q, pflags_d, penable_q;
  logic [3:0] port_last_q;
  logic ext_prev_q;
  logic [4:0] pins_s;
  logic ext_s;
  logic [3:0] port_s;

  csir_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .d({external_irq_pin, second_port_hi}),
    .q(pins_s)
  );
  assign ext_s = pins_s[4];
  assign port_s = pins_s[3:0];

  // apb decode, zero wait state
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [9:0] idx = paddr[11:2];
  wire hit_st = idx == {1'b0, `CSIR_IDX_STATUS};
  wire hit_ic = idx == {1'b0, `CSIR_IDX_INTCTL};
  wire hit_pf = idx == {1'b0, `CSIR_IDX_PFLAGS};
  wire hit_op = idx == {1'b0, `CSIR_IDX_OPTION};
  wire hit_pe = idx == {1'b0, `CSIR_IDX_PENABLE};
  wire hit_ev = idx == {1'b0, `CSIR_IDX_EVENTS};
  wire mapped = hit_st | hit_ic | hit_pf | hit_op | hit_pe | hit_ev;
  wire [7:0] wb = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || paddr[1:0] != 2'h0);
  wire wr_ok = wr && paddr[1:0] == 2'h0;

  // alu arithmetic
  wire [7:0] b_eff = (alu_op == csir_pkg::csir_op_sub) ? ~alu_b : alu_b;
  wire cin = alu_op == csir_pkg::csir_op_sub;
  wire [4:0] nib = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire [8:0] sum = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, cin};
  wire is_arith = alu_op == csir_pkg::csir_op_add ||
    alu_op == csir_pkg::csir_op_sub;
  wire is_rot = alu_op == csir_pkg::csir_op_rrf ||
    alu_op == csir_pkg::csir_op_rlf;
  wire upd_z = alu_op == csir_pkg::csir_op_logic || is_arith;
  logic [7:0] res;
  always_comb begin
    case (alu_op)
      csir_pkg::csir_op_add, csir_pkg::csir_op_sub: res = sum[7:0];
      csir_pkg::csir_op_rrf: res = {status_q[`CSIR_B_C], alu_a[7:1]};
      csir_pkg::csir_op_rlf: res = {alu_a[6:0], status_q[`CSIR_B_C]};
      csir_pkg::csir_op_logic: res = alu_b;
      default: res = alu_a;
    endcase
  end
  assign alu_result = res;
  wire rot_c = (alu_op == csir_pkg::csir_op_rrf) ? alu_a[0] : alu_a[7];

  // status next value
  always_comb begin
    status_d = status_q;
    if (alu_dest_status) begin
      status_d[7:5] = res[7:5];
      if (!upd_z) status_d[`CSIR_B_Z] = res[`CSIR_B_Z];
      if (!is_arith) status_d[`CSIR_B_DC] = res[`CSIR_B_DC];
      if (!is_arith && !is_rot) status_d[`CSIR_B_C] = res[`CSIR_B_C];
    end
    if (wr_ok && hit_st) begin
      status_d[7:5] = wb[7:5];
      status_d[2:0] = wb[2:0];
    end
    if (upd_z) status_d[`CSIR_B_Z] = res == 8'h00;
    if (is_arith) begin
      status_d[`CSIR_B_DC] = nib[4];
      status_d[`CSIR_B_C] = sum[8];
    end
    if (is_rot) status_d[`CSIR_B_C] = rot_c;
    if (watchdog_clear_instr || sleep_instr) begin
      status_d[`CSIR_B_TO] = 1'b1;
    end
    if (watchdog_timeout) status_d[`CSIR_B_TO] = 1'b0;
    if (watchdog_clear_instr) status_d[`CSIR_B_PD] = 1'b1;
    if (sleep_instr) status_d[`CSIR_B_PD] = 1'b0;
  end

  // interrupt sources, set wins over clear
  wire ext_rise = ext_s && !ext_prev_q;
  wire ext_fall = !ext_s && ext_prev_q;
  wire ext_evt = ext_irq_edge_sel ? ext_rise : ext_fall;
  wire mismatch = port_s != port_last_q;
  always_comb begin
    intctl_d = intctl_q;
    if (wr_ok && hit_ic) intctl_d = wb;
    if (timer0_overflow) intctl_d[`CSIR_B_T0IF] = 1'b1;
    if (ext_evt) intctl_d[`CSIR_B_EXT_PIN_IRQ_FLAG] = 1'b1;
    if (mismatch) intctl_d[`CSIR_B_PORT_CHANGE_FLAG] = 1'b1;
  end
  always_comb begin
    pflags_d = pflags_q;
    if (wr_ok && hit_pf) begin
      pflags_d[`CSIR_B_ADC] = wb[`CSIR_B_ADC] & HAS_ADC;
      pflags_d[2:0] = wb[2:0];
      pflags_d[`CSIR_B_SSP] = pflags_q[`CSIR_B_SSP] & wb[`CSIR_B_SSP];
    end
    pflags_d[7] = 1'b0;
    pflags_d[`CSIR_B_RX] = serial_rx_full;
    pflags_d[`CSIR_B_TX] = serial_tx_empty;
    if (sync_serial_done) pflags_d[`CSIR_B_SSP] = 1'b1;
    if (converter_done && HAS_ADC) pflags_d[`CSIR_B_ADC] = 1'b1;
    if (capcomp_event) pflags_d[2] = 1'b1;
    if (timer2_match) pflags_d[1] = 1'b1;
    if (timer1_overflow) pflags_d[0] = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_q <= `CSIR_RST_STATUS;
      option_q <= `CSIR_RST_OPTION;
      intctl_q <= `CSIR_RST_INTCTL;
      pflags_q <= `CSIR_RST_PFLAGS;
      penable_q <= `CSIR_RST_PENABLE;
      port_last_q <= 4'h0;
      ext_prev_q <= 1'b0;
    end else if (clk_en) begin
      status_q <= status_d;
      intctl_q <= intctl_d;
      pflags_q <= pflags_d;
      ext_prev_q <= ext_s;
      if (wr_ok && hit_op) option_q <= wb;
      if (wr_ok && hit_pe) begin
        penable_q <= {1'b0, wb[6] & HAS_ADC, wb[5:0]};
      end
      if (second_port_read) port_last_q <= port_s;
    end
  end

  // read mux
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    if (hit_st) rd = status_q;
    if (hit_ic) rd = intctl_q;
    if (hit_pf) rd = pflags_q;
    if (hit_op) rd = option_q;
    if (hit_pe) rd = penable_q;
    if (hit_ev) rd = {3'h0, ext_s, port_s};
  end
  assign prdata = {24'h000000, rd};

  // bank selection and option outputs
  assign indirect_bank_bit = status_q[`CSIR_B_IRP];
  assign direct_bank_field = status_q[6:5];
  assign direct_bank_base = {status_q[6:5], 7'h00};
  assign pullup_disable_n = option_q[7];
  assign ext_irq_edge_sel = option_q[6];
  assign timer0_source_sel = option_q[5];
  assign timer0_edge_sel = option_q[4];
  assign prescaler_owner_sel = option_q[3];
  // divide ratios: timer0 2..256 or 1:1, watchdog 1..128
  assign timer0_prescale_div = option_q[3] ? 9'h001 :
    9'h002 << option_q[2:0];
  assign watchdog_prescale_div = option_q[3] ?
    8'h01 << option_q[2:0] : 8'h01;

  // interrupt request
  wire core_hit = |(intctl_q[5:3] & intctl_q[2:0]);
  wire peri_hit = |(penable_q[6:0] & pflags_q[6:0]);
  assign irq_req = intctl_q[`CSIR_B_GIE] &&
    (core_hit || (intctl_q[`CSIR_B_PERIPHERAL_IRQ_GATE] && peri_hit));

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (srst)
    !intctl_q[7] |-> !irq_req) else $error("irq without global enable");
  a_zero_flag: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && upd_z && res == 8'h00 |=> status_q[2])
    else $error("zero flag not set");
  a_carry_add: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && is_arith |=> status_q[0] == $past(sum[8]))
    else $error("carry mismatch");
  a_rot_carry: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && alu_op == csir_pkg::csir_op_rrf |=>
    status_q[0] == $past(alu_a[0]))
    else $error("rotate carry wrong");
  a_to_clear: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && watchdog_timeout |=> !status_q[4])
    else $error("timeout bit not cleared");
  a_pd_sleep: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && sleep_instr |=> !status_q[3])
    else $error("powerdown bit not cleared");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && timer0_overflow |=> intctl_q[2])
    else $error("timer0 flag lost");
  a_pe_bit7: assert property (@(posedge ref_clk) disable iff (srst)
    !penable_q[7] && !pflags_q[7]) else $error("bit 7 not zero");
  a_t0_ratio: assert property (@(posedge ref_clk) disable iff (srst)
    option_q[3] |-> timer0_prescale_div == 9'h001)
    else $error("timer0 not 1:1");
  c_irq: cover property (@(posedge ref_clk) irq_req);
  c_mismatch: cover property (@(posedge ref_clk) mismatch ##1 second_port_read);
  c_status_wr: cover property (@(posedge ref_clk) wr_ok && hit_st);
endmodule

//--- test/tb.sv
// self-checking bench for the core status block, apb master and model inside
// assumes csir_core with default parameters and the register header
`timescale 1ns/1ps
`include "csir_regs.svh"
module tb;
  logic ref_clk = 0, srst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, last_err;
  csir_pkg::csir_op_t alu_op = csir_pkg::csir_op_none;
  logic [7:0] alu_a = 0, alu_b = 0, alu_result;
  logic alu_dest_status = 0, watchdog_clear_instr = 0, sleep_instr = 0;
  logic watchdog_timeout = 0, timer0_overflow = 0, external_irq_pin = 0;
  logic [3:0] second_port_hi = 0;
  logic second_port_read = 0, serial_rx_full = 0, serial_tx_empty = 0;
  logic sync_serial_done = 0, converter_done = 0, capcomp_event = 0;
  logic timer2_match = 0, timer1_overflow = 0, indirect_bank_bit;
  logic [1:0] direct_bank_field;
  logic [8:0] direct_bank_base, timer0_prescale_div, sum;
  logic pullup_disable_n, ext_irq_edge_sel, timer0_source_sel;
  logic timer0_edge_sel, prescaler_owner_sel, irq_req, dst;
  logic [7:0] watchdog_prescale_div, a, b, r, s, bb, v, m_st;
  localparam logic [11:0] a_st = {1'b0, `CSIR_IDX_STATUS, 2'b00};
  localparam logic [11:0] a_ic = {1'b0, `CSIR_IDX_INTCTL, 2'b00};
  localparam logic [11:0] a_pf = {1'b0, `CSIR_IDX_PFLAGS, 2'b00};
  localparam logic [11:0] a_op = {1'b0, `CSIR_IDX_OPTION, 2'b00};
  localparam logic [11:0] a_pe = {1'b0, `CSIR_IDX_PENABLE, 2'b00};
  int mismatches = 0, checks = 0, seed = 32'h3d9c, n, op;
  csir_core u_csir_core (.ref_clk, .srst, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .alu_op, .alu_a, .alu_b,
    .alu_dest_status, .watchdog_clear_instr, .sleep_instr, .watchdog_timeout,
    .timer0_overflow, .external_irq_pin, .second_port_hi, .second_port_read,
    .serial_rx_full, .serial_tx_empty, .sync_serial_done, .converter_done,
    .capcomp_event, .timer2_match, .timer1_overflow, .alu_result,
    .indirect_bank_bit, .direct_bank_field, .direct_bank_base,
    .pullup_disable_n, .ext_irq_edge_sel, .timer0_source_sel, .timer0_edge_sel,
    .prescaler_owner_sel, .timer0_prescale_div, .watchdog_prescale_div,
    .irq_req);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task summarize;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp, input string nm);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] d,
      output logic [31:0] rd_q);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge ref_clk) penable <= 1;
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 9) begin
      mismatches++;
      summarize;
    end
    rd_q = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task wr(input logic [11:0] ad, input logic [7:0] d);
    logic [31:0] x;
    apb(1, ad, d, x);
  endtask
  task rd(input logic [11:0] ad, input logic [7:0] e, input string nm);
    logic [31:0] x;
    apb(0, ad, 8'h00, x);
    chk(x, {24'h0, e}, nm);
  endtask
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  initial begin
    tick(4);
    srst <= 0;
    tick(1);
    rd(a_st, `CSIR_RST_STATUS, "status_rst");
    rd(a_op, 8'hff, "option_rst");
    rd(a_ic, 8'h00, "intctl_rst");
    watchdog_timeout <= 1;
    @(posedge ref_clk) watchdog_timeout <= 0;
    wr(a_st, 8'hff);
    rd(a_st, 8'hef, "status_expiry");
    sleep_instr <= 1;
    @(posedge ref_clk) sleep_instr <= 0;
    rd(a_st, 8'hf7, "status_sleep");
    watchdog_clear_instr <= 1;
    @(posedge ref_clk) watchdog_clear_instr <= 0;
    rd(a_st, 8'hff, "status_clear");
    for (n = 0; n < 8; n++) begin
      wr(a_st, 8'(n << 5));
      chk({indirect_bank_bit, direct_bank_field, direct_bank_base},
        {n[2], n[1:0], 9'(n[1:0] * 128)}, "bank_sel");
    end
    m_st = 8'hf8;
    for (n = 0; n < 40; n++) begin
      op = 1 + ($unsigned($random(seed)) % 5);
      a = 8'($random(seed));
      b = 8'($random(seed));
      dst = 1'($random(seed)) & (op == 2 || op == 3);
      s = m_st;
      bb = (op == 3) ? ~b : b;
      sum = a + bb + 9'(op == 3);
      case (op)
        1: begin
          r = b;
          s[2] = (b == 0);
        end
        2, 3: begin
          r = sum[7:0];
          s[2:0] = {r == 0, 5'(a[3:0]) + bb[3:0] + 5'(op == 3) > 15, sum[8]};
        end
        4: {r, s[0]} = {m_st[0], a};
        default: {s[0], r} = {a, m_st[0]};
      endcase
      if (dst) s[7:5] = r[7:5];
      alu_op <= csir_pkg::csir_op_t'(op);
      alu_a <= a;
      alu_b <= b;
      alu_dest_status <= dst;
      @(negedge ref_clk) chk(alu_result, r, "alu_result");
      @(posedge ref_clk) alu_op <= csir_pkg::csir_op_none;
      alu_dest_status <= 0;
      rd(a_st, s, "alu_flags");
      m_st = s;
    end
    for (n = 0; n < 16; n++) begin
      v = {4'($random(seed)), n[3:0]};
      wr(a_op, v);
      rd(a_op, v, "option_rw");
      chk({pullup_disable_n, ext_irq_edge_sel, timer0_source_sel,
        timer0_edge_sel, prescaler_owner_sel}, v[7:3],
        "opt_out");
      chk(timer0_prescale_div, v[3] ? 9'h1 : 9'h2 << v[2:0], "t0_div");
      if (v[3]) chk(watchdog_prescale_div, 8'h1 << v[2:0], "wd_div");
      else chk(watchdog_prescale_div, 8'h1, "wd_div_t0");
    end
    wr(a_op, 8'h40);
    timer0_overflow <= 1;
    @(posedge ref_clk) timer0_overflow <= 0;
    rd(a_ic, 8'h04, "t0_flag");
    chk(irq_req, 0, "irq_off");
    wr(a_ic, 8'ha4);
    chk(irq_req, 1, "irq_t0");
    wr(a_ic, 8'ha0);
    chk(irq_req, 0, "irq_clr");
    external_irq_pin <= 1;
    tick(4);
    rd(a_ic, 8'ha2, "ext_rise");
    wr(a_ic, 8'h00);
    external_irq_pin <= 0;
    tick(4);
    rd(a_ic, 8'h00, "ext_fall");
    wr(a_pe, 8'hff);
    rd(a_pe, 8'h7f, "penable");
    {sync_serial_done, converter_done, capcomp_event} <= 3'h7;
    {timer2_match, timer1_overflow} <= 2'h3;
    @(posedge ref_clk) {sync_serial_done, converter_done, capcomp_event} <= 0;
    {timer2_match, timer1_overflow} <= 2'h0;
    rd(a_pf, 8'h4f, "pflags_set");
    wr(a_ic, 8'h80);
    chk(irq_req, 0, "irq_pgate");
    wr(a_ic, 8'hc0);
    chk(irq_req, 1, "irq_periph");
    wr(a_pf, 8'h00);
    rd(a_pf, 8'h00, "pflags_clr");
    {serial_rx_full, serial_tx_empty} <= 2'h3;
    tick(2);
    wr(a_pf, 8'h00);
    rd(a_pf, 8'h30, "rxtx_ro");
    {serial_rx_full, serial_tx_empty} <= 2'h0;
    tick(2);
    rd(a_pf, 8'h00, "rxtx_follow");
    wr(a_ic, 8'h00);
    second_port_hi <= 4'ha;
    tick(4);
    rd(a_ic, 8'h01, "port_chg");
    wr(a_ic, 8'h00);
    rd(a_ic, 8'h01, "port_reset");
    second_port_read <= 1;
    @(posedge ref_clk) second_port_read <= 0;
    wr(a_ic, 8'h00);
    rd(a_ic, 8'h00, "port_read");
    rd(12'h008, 8'h00, "unmapped");
    chk(last_err, 1, "slverr");
    // frozen clock enable drops the overflow pulse
    clk_en <= 0;
    timer0_overflow <= 1;
    @(posedge ref_clk) timer0_overflow <= 0;
    clk_en <= 1;
    rd(a_ic, 8'h00, "clk_en_freeze");
    // mid-run reset brings registers back
    wr(a_op, 8'h00);
    srst <= 1;
    @(posedge ref_clk) srst <= 0;
    rd(a_st, `CSIR_RST_STATUS, "status_rst2");
    rd(a_op, 8'hff, "option_rst2");
    summarize;
  end
endmodule
